// File: trap_seq_regs.svh
// Constants for the trap and interrupt sequencer: vectors, trap levels, bit slots.
// Assumes 24-bit program addresses and 16-bit data addresses.
`ifndef TRAP_SEQ_REGS_SVH
`define TRAP_SEQ_REGS_SVH
`define RESET_VECTOR 24'h000000
`define PRI_TABLE_BASE 24'h000004
`define ALT_TABLE_BASE 24'h000084
`define PROG_END 24'h00ffff
`define STACK_FLOOR 16'h0800
`define NUM_IRQ 54
`define IRQ_IW 6
`define IRQ_VEC_OFS 6'h08
`define LVL_MATH 4'hb
`define LVL_ADDR 4'hc
`define LVL_STACK 4'hd
`define LVL_OSC 4'he
`define LVL_HARD_MIN 4'hc
`define VEC_OSC 6'h01
`define VEC_ADDR 6'h02
`define VEC_STACK 6'h03
`define VEC_MATH 6'h04
`define T_MATH 0
`define T_ADDR 1
`define T_STACK 2
`define T_OSC 3
`define RC_EXT 0
`define RC_POR 1
`define RC_WDT 2
`define RC_UNINIT 3
`define RC_ILLEGAL 4
`define RC_BROWNOUT 5
`define RC_TRAP 6
`define STK_DEPTH 16
`define STK_AW 4
`define STK_W 33
`define ENTRY_PC_TOP 23
`define ENTRY_LVL_LSB 29
`endif

// File: trap_seq_pkg.sv
// Types shared by the trap and interrupt sequencer files.
// Assumes trap_seq_regs.svh supplies the numeric constants.
package trap_seq_pkg;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_BOOT = 2'b01,
        ST_RUN = 2'b10,
        ST_VECT = 2'b11
    } seq_state_t;
    typedef logic [3:0] cpu_level_t;
    typedef logic [2:0] irq_prio_t;
endpackage

// File: context_stack.sv
// Small LIFO holding exception context (level, status flags, return address).
// Assumes the caller never pushes beyond its depth; an overflow wraps.
`timescale 1ns/10ps
`include "trap_seq_regs.svh"
module context_stack (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [`STK_W-1:0] wdata_i,
    output logic [`STK_W-1:0] rdata_o
);
    logic [`STK_W-1:0] mem_ff [`STK_DEPTH];
    logic [`STK_AW-1:0] sp_ff;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp_ff <= '0;
        end else if (clk_en_i) begin
            if (flush_i) begin
                sp_ff <= '0;
            end else if (push_i) begin
                sp_ff <= sp_ff + 1'b1;
            end else if (pop_i) begin
                sp_ff <= sp_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (clk_en_i && push_i && !flush_i) begin
            mem_ff[sp_ff] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else if (clk_en_i && pop_i) begin
            rdata_o <= mem_ff[sp_ff - 1'b1];
        end
    end
endmodule

// File: trap_and_interrupt_sequencer.sv
// Exception sequencer: reset entry, trap detection and priority, interrupt arbitration.
// Assumes the core reports instruction boundaries and fetches vectors on request.
`timescale 1ns/10ps
`include "trap_seq_regs.svh"
module trap_and_interrupt_sequencer (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic ext_reset_n_i,
    input wire logic por_i,
    input wire logic osc_fail_i,
    input wire logic watchdog_timeout_i,
    input wire logic uninit_w_ptr_i,
    input wire logic illegal_op_exec_i,
    input wire logic instr_flushed_i,
    input wire logic brownout_reset_i,
    input wire logic instr_done_i,
    input wire logic [23:0] pc_i,
    input wire logic [4:0] status_flags_i,
    input wire logic div_by_zero_i,
    input wire logic math_trap_en_i,
    input wire logic acc_ovf31_i,
    input wire logic guard_bits_used_i,
    input wire logic acc_ovf39_i,
    input wire logic saturation_en_i,
    input wire logic shift_over_max_i,
    input wire logic misaligned_i,
    input wire logic data_unimpl_i,
    input wire logic prog_data_unimpl_i,
    input wire logic fetch_in_vector_i,
    input wire logic mac_class_i,
    input wire logic x_access_in_y_i,
    input wire logic y_access_in_x_i,
    input wire logic branch_unimpl_i,
    input wire logic exec_unimpl_pc_i,
    input wire logic sp_write_i,
    input wire logic [15:0] sp_value_i,
    input wire logic [15:0] stack_limit_reg_i,
    input wire logic [3:0] trap_flag_clear_i,
    input wire logic [6:0] reset_cause_clear_i,
    input wire logic [`NUM_IRQ-1:0] irq_event_i,
    input wire logic [`NUM_IRQ-1:0] irq_flag_clear_i,
    input wire logic [`NUM_IRQ-1:0] int_enable_regs_i,
    input wire logic [3*`NUM_IRQ-1:0] irq_prio_i,
    input wire logic level_wr_i,
    input wire logic [2:0] level_wdata_i,
    input wire logic nesting_disable_i,
    input wire logic alt_table_select_i,
    input wire logic return_from_irq_i,
    input wire logic vector_valid_i,
    input wire logic [23:0] vector_data_i,
    output logic core_reset_o,
    output logic pc_load_o,
    output logic [23:0] pc_value_o,
    output logic vector_fetch_o,
    output logic [23:0] vector_addr_o,
    output logic [3:0] cpu_priority_level_o,
    output logic trap_level_flag_o,
    output logic core_stall_o,
    output logic [3:0] pending_traps_o,
    output logic [`NUM_IRQ-1:0] int_flag_regs_o,
    output logic [6:0] reset_cause_o,
    output logic trap_conflict_reset_flag_o
);
    trap_seq_pkg::seq_state_t state_ff;
    trap_seq_pkg::cpu_level_t level_ff;
    trap_seq_pkg::cpu_level_t hard_busy_ff;
    trap_seq_pkg::cpu_level_t hard_top;
    trap_seq_pkg::cpu_level_t trap_lvl;
    trap_seq_pkg::irq_prio_t best_prio;
    logic [`IRQ_IW-1:0] best_idx;
    logic [5:0] trap_vec;
    logic [`NUM_IRQ-1:0] irq_pend;
    logic [3:0] trap_evt;
    logic [3:0] trap_win;
    logic [6:0] cause_evt;
    logic [`IRQ_IW-1:0] irq_depth_ff;
    logic ext_s1_ff, ext_s2_ff, por_s1_ff, por_s2_ff, osc_s1_ff, osc_s2_ff, osc_d_ff;
    logic vec_bad_ff, pop_d_ff, conflict, reset_evt;
    logic boundary, trap_take, irq_take, take;
    logic [`STK_W-1:0] push_data;
    logic [`STK_W-1:0] pop_data;
    logic [23:0] tbl_base;

    // External reset, power-on and oscillator fail pins cross into this clock through two flops before any use
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_s1_ff <= 1'b1;
            ext_s2_ff <= 1'b1;
            por_s1_ff <= 1'b0;
            por_s2_ff <= 1'b0;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_d_ff <= 1'b0;
        end else if (clk_en_i) begin
            ext_s1_ff <= ext_reset_n_i;
            ext_s2_ff <= ext_s1_ff;
            por_s1_ff <= por_i;
            por_s2_ff <= por_s1_ff;
            osc_s1_ff <= osc_fail_i;
            osc_s2_ff <= osc_s1_ff;
            osc_d_ff <= osc_s2_ff;
        end
    end

    always_comb begin
        trap_evt[`T_MATH] = div_by_zero_i || shift_over_max_i || (math_trap_en_i &&
            ((acc_ovf31_i && !guard_bits_used_i) || (acc_ovf39_i && !saturation_en_i)));
        trap_evt[`T_ADDR] = misaligned_i || data_unimpl_i || prog_data_unimpl_i
            || fetch_in_vector_i || (mac_class_i && (x_access_in_y_i || y_access_in_x_i))
            || branch_unimpl_i || exec_unimpl_pc_i || vec_bad_ff;
        trap_evt[`T_STACK] = sp_write_i &&
            (sp_value_i > stack_limit_reg_i || sp_value_i < `STACK_FLOOR);
        trap_evt[`T_OSC] = osc_s2_ff && !osc_d_ff;
    end

    // Highest hard level already pending or in service
    always_comb begin
        hard_top = hard_busy_ff;
        if (pending_traps_o[`T_ADDR] && hard_top < `LVL_ADDR) begin
            hard_top = `LVL_ADDR;
        end
        if (pending_traps_o[`T_STACK] && hard_top < `LVL_STACK) begin
            hard_top = `LVL_STACK;
        end
        if (pending_traps_o[`T_OSC]) begin
            hard_top = `LVL_OSC;
        end
    end

    // Same-cycle hard traps are ordered by priority, not treated as a conflict
    assign conflict = (trap_evt[`T_ADDR] && hard_top > `LVL_ADDR)
        || (trap_evt[`T_STACK] && hard_top > `LVL_STACK);

    assign cause_evt[`RC_EXT] = !ext_s2_ff;
    assign cause_evt[`RC_POR] = por_s2_ff;
    assign cause_evt[`RC_WDT] = watchdog_timeout_i;
    assign cause_evt[`RC_UNINIT] = uninit_w_ptr_i;
    assign cause_evt[`RC_ILLEGAL] = illegal_op_exec_i && !instr_flushed_i;
    assign cause_evt[`RC_BROWNOUT] = brownout_reset_i;
    assign cause_evt[`RC_TRAP] = conflict;
    assign reset_evt = |cause_evt;

    // Reset cause flags survive the resets they report; a new cause beats a clear
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_cause_o <= '0;
            trap_conflict_reset_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            reset_cause_o <= (reset_cause_o & ~reset_cause_clear_i) | cause_evt;
            trap_conflict_reset_flag_o <= (trap_conflict_reset_flag_o && !reset_cause_clear_i[`RC_TRAP])
                || conflict;
        end
    end

    // Interrupt flags: an event in the clearing cycle still sets the flag
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_flag_regs_o <= '0;
        end else if (clk_en_i) begin
            if (reset_evt) begin
                int_flag_regs_o <= '0;
            end else begin
                int_flag_regs_o <= (int_flag_regs_o & ~irq_flag_clear_i) | irq_event_i;
            end
        end
    end

    for (genvar g = 0; g < `NUM_IRQ; g++) begin : g_pend
        assign irq_pend[g] = int_flag_regs_o[g] && int_enable_regs_i[g]
            && (irq_prio_i[3*g +: 3] != 3'h0);
    end

    // Scan from the top so that ties settle on the lowest index
    always_comb begin
        best_prio = 3'h0;
        best_idx = '0;
        for (int i = `NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_pend[i] && irq_prio_i[3*i +: 3] >= best_prio) begin
                best_prio = irq_prio_i[3*i +: 3];
                best_idx = `IRQ_IW'(i);
            end
        end
    end

    // Fixed trap priority: oscillator, stack, address, math
    always_comb begin
        trap_win = 4'h0;
        trap_lvl = 4'h0;
        trap_vec = 6'h00;
        if (pending_traps_o[`T_OSC]) begin
            trap_win[`T_OSC] = 1'b1;
            trap_lvl = `LVL_OSC;
            trap_vec = `VEC_OSC;
        end else if (pending_traps_o[`T_STACK]) begin
            trap_win[`T_STACK] = 1'b1;
            trap_lvl = `LVL_STACK;
            trap_vec = `VEC_STACK;
        end else if (pending_traps_o[`T_ADDR]) begin
            trap_win[`T_ADDR] = 1'b1;
            trap_lvl = `LVL_ADDR;
            trap_vec = `VEC_ADDR;
        end else if (pending_traps_o[`T_MATH]) begin
            trap_win[`T_MATH] = 1'b1;
            trap_lvl = `LVL_MATH;
            trap_vec = `VEC_MATH;
        end
    end

    assign boundary = (state_ff == trap_seq_pkg::ST_RUN) && (instr_done_i || div_by_zero_i);
    assign trap_take = boundary && (trap_lvl > level_ff);
    assign irq_take = boundary && !trap_take && ({1'b0, best_prio} > level_ff)
        && !(nesting_disable_i && irq_depth_ff != '0);
    assign take = trap_take || irq_take;
    assign tbl_base = alt_table_select_i ? `ALT_TABLE_BASE : `PRI_TABLE_BASE;
    assign push_data = {level_ff, status_flags_i, pc_i};

    // Lower pending traps stay visible for software to inspect
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_traps_o <= '0;
        end else if (clk_en_i) begin
            if (reset_evt) begin
                pending_traps_o <= '0;
            end else begin
                pending_traps_o <= (pending_traps_o & ~trap_flag_clear_i) | trap_evt;
            end
        end
    end

    // Hard traps hold the core until taken
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_stall_o <= 1'b0;
        end else if (clk_en_i) begin
            core_stall_o <= !reset_evt && trap_lvl >= `LVL_HARD_MIN && trap_lvl > level_ff && !take;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= trap_seq_pkg::ST_RESET;
            core_reset_o <= 1'b1;
            pc_load_o <= 1'b0;
            pc_value_o <= `RESET_VECTOR;
            vector_fetch_o <= 1'b0;
            vector_addr_o <= `PRI_TABLE_BASE;
            vec_bad_ff <= 1'b0;
        end else if (clk_en_i) begin
            pc_load_o <= 1'b0;
            vector_fetch_o <= 1'b0;
            vec_bad_ff <= 1'b0;
            core_reset_o <= 1'b0;
            if (reset_evt) begin
                state_ff <= trap_seq_pkg::ST_RESET;
                core_reset_o <= 1'b1;
            end else begin
                case (state_ff)
                    trap_seq_pkg::ST_RESET: begin
                        state_ff <= trap_seq_pkg::ST_BOOT;
                    end
                    trap_seq_pkg::ST_BOOT: begin
                        pc_load_o <= 1'b1;
                        pc_value_o <= `RESET_VECTOR;
                        state_ff <= trap_seq_pkg::ST_RUN;
                    end
                    trap_seq_pkg::ST_RUN: begin
                        if (take) begin
                            vector_fetch_o <= 1'b1;
                            vector_addr_o <= tbl_base + {17'h00000, trap_take ? trap_vec
                                : best_idx + `IRQ_VEC_OFS, 1'b0};
                            state_ff <= trap_seq_pkg::ST_VECT;
                        end else if (pop_d_ff) begin
                            pc_load_o <= 1'b1;
                            pc_value_o <= pop_data[`ENTRY_PC_TOP:0];
                        end
                    end
                    trap_seq_pkg::ST_VECT: begin
                        if (vector_valid_i) begin
                            state_ff <= trap_seq_pkg::ST_RUN;
                            if (vector_data_i > `PROG_END) begin
                                vec_bad_ff <= 1'b1;
                            end else begin
                                pc_load_o <= 1'b1;
                                pc_value_o <= vector_data_i;
                            end
                        end
                    end
                    default: begin
                        state_ff <= trap_seq_pkg::ST_RESET;
                    end
                endcase
            end
        end
    end

    // Processor level, nesting depth and hard trap occupancy
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_ff <= 4'h0;
            irq_depth_ff <= '0;
            hard_busy_ff <= 4'h0;
            pop_d_ff <= 1'b0;
        end else if (clk_en_i) begin
            pop_d_ff <= 1'b0;
            if (reset_evt) begin
                level_ff <= 4'h0;
                irq_depth_ff <= '0;
                hard_busy_ff <= 4'h0;
            end else if (trap_take) begin
                level_ff <= trap_lvl;
                if (trap_lvl >= `LVL_HARD_MIN && trap_lvl > hard_busy_ff) begin
                    hard_busy_ff <= trap_lvl;
                end
            end else if (irq_take) begin
                level_ff <= {1'b0, best_prio};
                irq_depth_ff <= irq_depth_ff + 1'b1;
            end else if (return_from_irq_i && state_ff == trap_seq_pkg::ST_RUN) begin
                pop_d_ff <= 1'b1;
                if (!level_ff[3] && irq_depth_ff != '0) begin
                    irq_depth_ff <= irq_depth_ff - 1'b1;
                end
                if (level_ff >= `LVL_HARD_MIN) begin
                    hard_busy_ff <= 4'h0;
                end
            end else if (pop_d_ff) begin
                level_ff <= pop_data[`STK_W-1:`ENTRY_LVL_LSB];
            end else if (level_wr_i && !nesting_disable_i) begin
                level_ff <= {level_ff[3], level_wdata_i};
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_priority_level_o <= 4'h0;
            trap_level_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            cpu_priority_level_o <= level_ff;
            trap_level_flag_o <= level_ff[3];
        end
    end

    context_stack context_stack_i (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .flush_i(reset_evt),
        .push_i(take),
        .pop_i(return_from_irq_i && !take && state_ff == trap_seq_pkg::ST_RUN),
        .wdata_i(push_data),
        .rdata_o(pop_data)
    );
endmodule

// File: trap_seq_sva.sv
// Port checker for the trap and interrupt sequencer: reset entry, trap levels, vectors, conflicts.
// Assumes clk_en_i stays high while trap and cause terms are pulsed.
`timescale 1ns/10ps
module trap_seq_sva (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic illegal_op_exec_i,
    input wire logic instr_flushed_i,
    input wire logic div_by_zero_i,
    input wire logic sp_write_i,
    input wire logic [15:0] sp_value_i,
    input wire logic alt_table_select_i,
    input wire logic core_reset_o,
    input wire logic pc_load_o,
    input wire logic [23:0] pc_value_o,
    input wire logic vector_fetch_o,
    input wire logic [23:0] vector_addr_o,
    input wire logic [3:0] cpu_priority_level_o,
    input wire logic trap_level_flag_o,
    input wire logic core_stall_o,
    input wire logic [3:0] pending_traps_o,
    input wire logic [6:0] reset_cause_o,
    input wire logic trap_conflict_reset_flag_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic trap_vec;
    // Trap slots are entries 1 to 4 of either table
    assign trap_vec = (vector_addr_o < 24'h00000e) || (vector_addr_o >= 24'h000084 && vector_addr_o < 24'h00008e);
    chk_boot_zero: assert property ($fell(core_reset_o) |=> pc_load_o && pc_value_o == 24'h000000)
        else $error("boot did not load program counter zero");
    chk_illegal_op_rst: assert property (clk_en_i && illegal_op_exec_i && !instr_flushed_i |->
        ##[1:3] (core_reset_o && reset_cause_o[4])) else $error("executed illegal opcode did not reset");
    chk_flushed_quiet: assert property (illegal_op_exec_i && instr_flushed_i && !reset_cause_o[4]
        |=> !reset_cause_o[4]) else $error("flushed opcode raised a reset cause");
    chk_trap_bit: assert property ($rose(trap_level_flag_o) |-> $past(vector_fetch_o) && $past(trap_vec))
        else $error("trap flag rose without a trap vector");
    chk_trap_class: assert property (vector_fetch_o |=> trap_level_flag_o == $past(trap_vec))
        else $error("trap flag wrong for vector kind");
    chk_level_rises: assert property (vector_fetch_o |=> cpu_priority_level_o > $past(cpu_priority_level_o))
        else $error("exception taken without higher priority");
    chk_alt_table: assert property (vector_fetch_o |-> (vector_addr_o >= 24'h000084) == alt_table_select_i)
        else $error("vector fetched from wrong table");
    chk_div_math: assert property (clk_en_i && div_by_zero_i |=> pending_traps_o[0])
        else $error("divide by zero left math trap idle");
    chk_stack_floor: assert property (clk_en_i && sp_write_i && sp_value_i < 16'h0800
        && pending_traps_o[3:1] == 3'h0 |=> pending_traps_o[2]) else $error("stack underflow not trapped");
    chk_stall_hard: assert property (core_stall_o |-> pending_traps_o[3:1] != 3'h0)
        else $error("stall without pending hard trap");
    chk_conflict_rst: assert property ($rose(trap_conflict_reset_flag_o) |-> core_reset_o && reset_cause_o[6])
        else $error("conflict flag without reset");
    cover property (vector_fetch_o && trap_vec);
    cover property (vector_fetch_o && alt_table_select_i);
    cover property ($rose(trap_conflict_reset_flag_o));
endmodule
bind trap_and_interrupt_sequencer trap_seq_sva trap_seq_sva_i (.*);

// File: core_vec_model.sv
// Core-side model: answers each vector fetch with a handler word after a set delay.
// Assumes the bench picks the delay and whether the word is out of program range.
`timescale 1ns/10ps
module core_vec_model (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic vector_fetch_o,
    input wire logic [23:0] vector_addr_o,
    input wire logic [3:0] delay_i,
    input wire logic bad_i,
    output logic vec_valid_o,
    output logic [23:0] vec_data_o
);
    logic [4:0] cnt_ff;
    always @(posedge clock_i or negedge reset_n_i) begin
        vec_valid_o <= 1'h0;
        // Word changes every idle cycle so a late sample cannot pass by luck
        vec_data_o <= ~vec_data_o;
        if (!reset_n_i) begin
            cnt_ff <= 5'h00;
            vec_data_o <= 24'h5a5a5a;
        end else if (vector_fetch_o) begin
            cnt_ff <= {1'h0, delay_i} + 5'h01;
        end else if (cnt_ff == 5'h01) begin
            cnt_ff <= 5'h00;
            vec_valid_o <= 1'h1;
            vec_data_o <= bad_i ? 24'h010000 : 24'h002000 + vector_addr_o;
        end else if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
        end
    end
endmodule

// File: trap_and_interrupt_sequencer_test.sv
// Self-checking bench for the trap and interrupt sequencer with a core vector model.
// Assumes a 10 MHz clock; each scenario except t_causes starts from a fresh reset.
`timescale 1ns/10ps
module trap_and_interrupt_sequencer_test;
    logic clock_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1, ext_reset_n_i = 1'h1, por_i = 1'h0, osc_fail_i = 1'h0;
    logic instr_flushed_i = 1'h0, instr_done_i = 1'h0, div_by_zero_i = 1'h0, math_trap_en_i = 1'h0;
    logic acc_ovf31_i = 1'h0, guard_bits_used_i = 1'h0, acc_ovf39_i = 1'h0, saturation_en_i = 1'h0;
    logic shift_over_max_i = 1'h0, misaligned_i = 1'h0, data_unimpl_i = 1'h0, prog_data_unimpl_i = 1'h0;
    logic fetch_in_vector_i = 1'h0, mac_class_i = 1'h0, x_access_in_y_i = 1'h0, y_access_in_x_i = 1'h0;
    logic branch_unimpl_i = 1'h0, exec_unimpl_pc_i = 1'h0, sp_write_i = 1'h0, level_wr_i = 1'h0, bad = 1'h0;
    logic nesting_disable_i = 1'h0, alt_table_select_i = 1'h0, return_from_irq_i = 1'h0, vector_valid_i;
    logic [15:0] sp_value_i = 16'h0000, stack_limit_reg_i = 16'h4000;
    logic [23:0] pc_i = 24'h001234, vector_data_i, pc_value_o, vector_addr_o, fa;
    logic [4:0] status_flags_i = 5'h0a;
    logic [3:0] trap_flag_clear_i = 4'h0, rc = 4'h0, dly = 4'h0, cpu_priority_level_o, pending_traps_o;
    logic [6:0] reset_cause_clear_i = 7'h00, reset_cause_o;
    logic [53:0] irq_event_i = 54'h0, irq_flag_clear_i = 54'h0, int_enable_regs_i = 54'h0, int_flag_regs_o;
    logic [161:0] irq_prio_i = 162'h0;
    logic [2:0] level_wdata_i = 3'h7;
    logic core_reset_o, pc_load_o, vector_fetch_o, trap_level_flag_o, core_stall_o, trap_conflict_reset_flag_o;
    int err_total = 0, checked = 0, fetches = 0, f0 = 0;
    trap_and_interrupt_sequencer trap_and_interrupt_sequencer_i (.*, .watchdog_timeout_i(rc[0]),
        .uninit_w_ptr_i(rc[1]), .illegal_op_exec_i(rc[2]), .brownout_reset_i(rc[3]));
    core_vec_model core_vec_model_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .vector_fetch_o(vector_fetch_o),
        .vector_addr_o(vector_addr_o), .delay_i(dly), .bad_i(bad), .vec_valid_o(vector_valid_i),
        .vec_data_o(vector_data_i));
    always #50 clock_i = ~clock_i;
    // Fetch pulses last one cycle, so they are counted here rather than polled
    always @(posedge clock_i) begin
        if (vector_fetch_o === 1'h1) begin
            fetches++;
            fa = vector_addr_o;
        end
    end
    task final_report;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cyc(input int n = 1);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task await_load;
        int n;
        n = 0;
        while (pc_load_o !== 1'h1 && n < 12) begin
            cyc();
            n++;
        end
        chk("load seen", n < 12, 1'h1);
    endtask
    task boot;
        await_load();
        chk("boot pc", pc_value_o, 24'h000000);
        cyc(2);
        f0 = fetches;
    endtask
    task rst;
        reset_n_i = 1'h0;
        {alt_table_select_i, nesting_disable_i, bad, dly, int_enable_regs_i, irq_prio_i} = 0;
        cyc(10);
        reset_n_i = 1'h1;
        boot();
    endtask
    task irq(input logic [53:0] m);
        irq_event_i = m;
        cyc();
        irq_event_i = 54'h0;
        instr_done_i = 1'h1;
        cyc();
        instr_done_i = 1'h0;
    endtask
    task take(input logic [23:0] addr, input logic [3:0] lvl);
        int n;
        n = 0;
        while (fetches == f0 && n < 12) begin
            cyc();
            n++;
        end
        chk("vector addr", fa, addr);
        chk("level", cpu_priority_level_o, lvl);
        await_load();
        chk("handler", pc_value_o, 24'h002000 + addr);
        f0 = fetches;
    endtask
    task t_irq;
        int_enable_regs_i = 54'h20;
        irq_prio_i[17:15] = 3'h3;
        irq(54'h20);
        chk("flag", int_flag_regs_o[5], 1'h1);
        take(24'h00001e, 4'h3);
        irq_flag_clear_i = 54'h20;
        return_from_irq_i = 1'h1;
        cyc();
        irq_flag_clear_i = 54'h0;
        return_from_irq_i = 1'h0;
        await_load();
        chk("return pc", pc_value_o, pc_i);
        cyc(3);
        chk("return level", cpu_priority_level_o, 4'h0);
    endtask
    task t_tie;
        alt_table_select_i = 1'h1;
        int_enable_regs_i = 54'h205;
        irq_prio_i[29:27] = 3'h4;
        irq_prio_i[8:6] = 3'h4;
        irq(54'h205);
        take(24'h000098, 4'h4);
        nesting_disable_i = 1'h1;
        irq_prio_i[29:27] = 3'h5;
        irq(54'h0);
        cyc(4);
        chk("nested", fetches - f0, 24'h0);
    endtask
    task t_mask;
        level_wr_i = 1'h1;
        cyc();
        level_wr_i = 1'h0;
        int_enable_regs_i = 54'h1;
        irq_prio_i[2:0] = 3'h7;
        irq(54'h1);
        cyc(4);
        chk("masked", fetches - f0, 24'h0);
        div_by_zero_i = 1'h1;
        cyc();
        div_by_zero_i = 1'h0;
        instr_done_i = 1'h1;
        cyc();
        instr_done_i = 1'h0;
        take(24'h00000c, 4'hb);
        chk("trap bit", trap_level_flag_o, 1'h1);
    endtask
    task t_hard;
        misaligned_i = 1'h1;
        sp_write_i = 1'h1;
        sp_value_i = 16'h07fe;
        cyc();
        {misaligned_i, sp_write_i} = 2'h0;
        cyc();
        chk("pending", pending_traps_o, 4'h6);
        chk("stall", core_stall_o, 1'h1);
        irq(54'h0);
        take(24'h00000a, 4'hd);
        chk("stall off", core_stall_o, 1'h0);
        chk("lower kept", pending_traps_o, 4'h6);
    endtask
    task t_conflict;
        sp_write_i = 1'h1;
        sp_value_i = 16'hff00;
        cyc();
        sp_write_i = 1'h0;
        cyc();
        misaligned_i = 1'h1;
        cyc();
        misaligned_i = 1'h0;
        cyc();
        chk("conflict", trap_conflict_reset_flag_o, 1'h1);
        chk("conflict cause", reset_cause_o[6], 1'h1);
        boot();
        chk("traps cleared", pending_traps_o, 4'h0);
    endtask
    task t_causes;
        for (int i = 0; i < 4; i++) begin
            rc = 4'h1 << i;
            cyc();
            rc = 4'h0;
            cyc();
            chk("cause", reset_cause_o[i+2], 1'h1);
            boot();
        end
        reset_cause_clear_i = 7'h7f;
        cyc();
        {reset_cause_clear_i, instr_flushed_i, rc} = {7'h00, 1'h1, 4'h4};
        cyc();
        {instr_flushed_i, rc} = 0;
        cyc(3);
        chk("flushed", reset_cause_o[4], 1'h0);
    endtask
    task t_bad;
        dly = 4'h5;
        bad = 1'h1;
        int_enable_regs_i = 54'h20;
        irq_prio_i[17:15] = 3'h2;
        irq(54'h20);
        cyc(12);
        chk("bad vector", pending_traps_o[1], 1'h1);
        osc_fail_i = 1'h1;
        cyc(4);
        chk("osc trap", pending_traps_o[3], 1'h1);
    endtask
    initial begin
        rst();
        t_irq();
        rst();
        t_tie();
        rst();
        t_mask();
        rst();
        t_hard();
        rst();
        t_conflict();
        t_causes();
        rst();
        t_bad();
        final_report();
    end
    // About 200 cycles are needed; the limit leaves a wide margin
    initial begin
        #1000000;
        err_total++;
        final_report();
    end
endmodule
